// [efc_coef_regs.sv]
// Purpose: APB register bank holding equaliser filter tap coefficients.
// Assumes: Inputs synchronous to mclk; sys_rst synchronous, active high.
// Notes:   Every APB transfer takes one wait state.
//
// Notes on behaviour
// - Low twelve bits hold a signed two's-complement tap coefficient.
// - Channel-A tap-7 register drives A tap 7, also single filter.
// - Index 0x427 drives tap 8 of channel-A or single filter.
// - Index 0x429 drives last tap 9 of channel-A or single filter.
// - Index 0x448 drives channel-B tap 1, applied only in dual mode.
// - Index 0x44A drives channel-B tap 2 in dual-channel operation.
// - All coefficient registers, reserved bits included, reset to zero.
// - Filter has nine taps; centre tap coefficient is eighteen bits.
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`include "efc_defs.svh"

module efc_coef_regs
   import efc_pkg::*;
(
   input  wire logic                     mclk,
   input  wire logic                     sys_rst,
   input  wire logic                     ce,
   input  wire logic                     single_chan_mode,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [`EFC_ADDR_W-1:0]   paddr,
   input  wire logic [`EFC_DATA_W-1:0]   pwdata,
   input  wire logic [3:0]               pstrb,
   output logic                          pready,
   output logic      [`EFC_DATA_W-1:0]   prdata,
   output logic                          pslverr,
   output efc_coef_t                     a_tap7_coef,
   output efc_coef_t                     a_tap8_coef,
   output efc_coef_t                     a_tap9_coef,
   output efc_coef_t                     b_tap1_coef,
   output efc_coef_t                     b_tap2_coef
);

   // ****************************************************************
   // Address decode
   // ****************************************************************
   logic [`EFC_IDX_W-1:0] idx;
   logic                  aligned;
   logic                  hit;
   logic                  is_info;
   efc_slot_t             slot;

   assign idx     = paddr[`EFC_ADDR_W-1:2];
   assign aligned = (paddr[1:0] == 2'h0);

   always_comb begin
      hit     = aligned;
      is_info = 1'b0;
      slot    = 3'h0;
      unique case (idx)
         `EFC_IDX_A_TAP7: slot = 3'h0;
         `EFC_IDX_A_TAP8: slot = 3'h1;
         `EFC_IDX_A_TAP9: slot = 3'h2;
         `EFC_IDX_B_TAP1: slot = 3'h3;
         `EFC_IDX_B_TAP2: slot = 3'h4;
         `EFC_IDX_INFO:   is_info = 1'b1;
         default:         hit = 1'b0;
      endcase
   end

   // ****************************************************************
   // Bus handshake
   // ****************************************************************
   efc_state_t              state_r;
   efc_state_t              state_nxt;
   logic                    pready_r;
   logic                    pready_nxt;
   logic [`EFC_DATA_W-1:0]  prdata_r;
   logic [`EFC_DATA_W-1:0]  prdata_nxt;
   logic                    pslverr_r;
   logic                    pslverr_nxt;
   logic                    wr_go;
   efc_word_t               regs_r [`EFC_NUM_REGS];
   efc_word_t               regs_nxt [`EFC_NUM_REGS];

   // Write lands only at the edge where the master sees pready high
   assign wr_go = psel && penable && pwrite && (state_r == EFC_ST_ANSW)
                  && hit && !is_info;

   always_comb begin
      state_nxt   = state_r;
      pready_nxt  = 1'b0;
      prdata_nxt  = prdata_r;
      pslverr_nxt = 1'b0;
      unique case (state_r)
         EFC_ST_IDLE: begin
            if (psel && penable) begin
               state_nxt   = EFC_ST_ANSW;
               pready_nxt  = 1'b1;
               pslverr_nxt = !hit;
               prdata_nxt  = 32'h0000_0000;
               if (!pwrite && hit) begin
                  if (is_info)
                     prdata_nxt = {16'h0000, 2'h0, 6'(`EFC_CENTER_W),
                                   `EFC_NUM_TAPS};
                  else
                     prdata_nxt = {16'h0000, regs_r[slot]};
               end
            end
         end
         EFC_ST_ANSW: begin
            state_nxt = EFC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_r   <= EFC_ST_IDLE;
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (ce) begin
         state_r   <= state_nxt;
         pready_r  <= pready_nxt;
         prdata_r  <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign pready  = pready_r;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;

   // ****************************************************************
   // Coefficient storage
   // ****************************************************************
   // Reserved nibble is stored so software reads back what it wrote
   genvar gi;
   generate
      for (gi = 0; gi < `EFC_NUM_REGS; gi++) begin : g_reg
         always_comb begin
            regs_nxt[gi] = regs_r[gi];
            if (wr_go && (slot == 3'(gi))) begin
               if (pstrb[0])
                  regs_nxt[gi][7:0] = pwdata[7:0];
               if (pstrb[1])
                  regs_nxt[gi][15:8] = pwdata[15:8];
            end
         end

         always_ff @(posedge mclk) begin
            if (sys_rst)
               regs_r[gi] <= `EFC_REG_RST;
            else if (ce)
               regs_r[gi] <= regs_nxt[gi];
         end
      end
   endgenerate

   // ****************************************************************
   // Filter tap outputs
   // ****************************************************************
   efc_coef_t a7_r;
   efc_coef_t a8_r;
   efc_coef_t a9_r;
   efc_coef_t b1_r;
   efc_coef_t b2_r;
   efc_coef_t a7_nxt;
   efc_coef_t a8_nxt;
   efc_coef_t a9_nxt;
   efc_coef_t b1_nxt;
   efc_coef_t b2_nxt;

   // Taps lag the register by one cycle; reserved bits are cut off here
   always_comb begin
      a7_nxt = efc_coef_t'(regs_r[0][`EFC_COEF_MSB:0]);
      a8_nxt = efc_coef_t'(regs_r[1][`EFC_COEF_MSB:0]);
      a9_nxt = efc_coef_t'(regs_r[2][`EFC_COEF_MSB:0]);
      b1_nxt = `EFC_COEF_RST;
      b2_nxt = `EFC_COEF_RST;
      // Channel B idles with null taps when only one channel runs
      if (!single_chan_mode) begin
         b1_nxt = efc_coef_t'(regs_r[3][`EFC_COEF_MSB:0]);
         b2_nxt = efc_coef_t'(regs_r[4][`EFC_COEF_MSB:0]);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         a7_r <= `EFC_COEF_RST;
         a8_r <= `EFC_COEF_RST;
         a9_r <= `EFC_COEF_RST;
         b1_r <= `EFC_COEF_RST;
         b2_r <= `EFC_COEF_RST;
      end else if (ce) begin
         a7_r <= a7_nxt;
         a8_r <= a8_nxt;
         a9_r <= a9_nxt;
         b1_r <= b1_nxt;
         b2_r <= b2_nxt;
      end
   end

   assign a_tap7_coef = a7_r;
   assign a_tap8_coef = a8_r;
   assign a_tap9_coef = a9_r;
   assign b_tap1_coef = b1_r;
   assign b_tap2_coef = b2_r;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   chk_reset_zero_a7: assert property (
      $past(sys_rst) |-> (regs_r[0] == 16'h0000 && a7_r == 12'h000))
      else $error("tap 7 not zero after reset");

   chk_tap7_follows: assert property (
      ce && $past(ce) |=> a7_r == $past(regs_r[0][11:0], 1))
      else $error("channel A tap 7 does not follow its register");

   chk_tap8_write: assert property (
      (wr_go && slot == 3'h1 && pstrb[1:0] == 2'h3 && ce)
      |=> regs_r[1] == $past(pwdata[15:0]))
      else $error("tap 8 write lost");

   chk_tap9_follows: assert property (
      ce && $past(ce) |=> a9_r == $past(regs_r[2][11:0], 1))
      else $error("channel A tap 9 does not follow its register");

   chk_b1_single_null: assert property (
      ce && single_chan_mode |=> b1_r == 12'h000)
      else $error("channel B tap 1 live in single mode");

   chk_b2_dual_live: assert property (
      ce && !single_chan_mode |=> b2_r == $past(regs_r[4][11:0]))
      else $error("channel B tap 2 not applied in dual mode");

   chk_sign_kept: assert property (
      ce && $past(ce) |=> a8_r[11] == $past(regs_r[1][11], 1))
      else $error("sign bit of tap 8 lost");

   chk_resv_blocked: assert property (
      ce && $stable(regs_r[0][11:0]) && $changed(regs_r[0][15:12])
      |=> $stable(a7_r))
      else $error("reserved bits disturbed tap 7");

   chk_answer_once: assert property (
      ce && psel && penable && state_r == EFC_ST_IDLE
      |=> pready ##1 (!pready || !$past(ce)))
      else $error("pready not a single cycle");

   chk_info_taps: assert property (
      pready && !pslverr && is_info && !pwrite |-> prdata[7:0] == 8'h09)
      else $error("tap count misreported");

   // ****************************************************************
   // Tap output, storage and bus answer checks
   // ****************************************************************
   chk_tap8_follows: assert property (
      ce |=> a8_r == $past(regs_r[1][11:0]))
      else $error("channel A tap 8 does not follow its register");

   chk_b1_dual_live: assert property (
      ce && !single_chan_mode |=> b1_r == $past(regs_r[3][11:0]))
      else $error("channel B tap 1 not applied in dual mode");

   chk_b2_single_null: assert property (
      ce && single_chan_mode |=> b2_r == 12'h000)
      else $error("channel B tap 2 live in single mode");

   chk_reset_zero_all: assert property (
      $past(sys_rst) |-> (regs_r[1] == 16'h0000 && regs_r[2] == 16'h0000
         && regs_r[3] == 16'h0000 && regs_r[4] == 16'h0000
         && a8_r == 12'h000 && a9_r == 12'h000
         && b1_r == 12'h000 && b2_r == 12'h000))
      else $error("coefficient bank not zero after reset");

   chk_bus_reset_idle: assert property (
      $past(sys_rst) |-> (!pready && !pslverr && prdata == 32'h0000_0000))
      else $error("bus answer not idle after reset");

   chk_info_width: assert property (
      pready && !pslverr && is_info && !pwrite |-> prdata[13:8] == 6'h12)
      else $error("centre tap width misreported");

   // Software may keep its own flags in the nibble, so it must survive
   chk_resv_stored: assert property (
      wr_go && slot == 3'h0 && pstrb[1] && ce
      |=> regs_r[0][15:12] == $past(pwdata[15:12]))
      else $error("reserved nibble of tap 7 not stored");

   chk_miss_dropped: assert property (
      pready && pslverr && pwrite
      |=> $stable({regs_r[0], regs_r[1], regs_r[2], regs_r[3], regs_r[4]}))
      else $error("refused write changed a register");

   chk_err_with_ready: assert property (
      pslverr |-> pready)
      else $error("error flag raised outside an answer");

   chk_read_data: assert property (
      pready && !pslverr && !pwrite && !is_info
      |-> prdata == {16'h0000, regs_r[slot]})
      else $error("read data does not match the addressed register");

   cov_write_b1: cover property (wr_go && slot == 3'h3);
   cov_read_a9:  cover property (pready && !pwrite && slot == 3'h2 && hit);
   cov_unmapped: cover property (pready && pslverr);
   cov_mode_sw:  cover property (single_chan_mode ##1 !single_chan_mode);
   cov_info_rd:  cover property (pready && !pslverr && is_info && !pwrite);

endmodule

// [efc_defs.svh]
// Purpose: Offsets, field positions, reset values for the equaliser
//          filter coefficient bank.
// Assumes: APB, 32-bit data, one aligned word per register.
// Notes:   Printed offsets are word indices; byte address is index * 4.
`ifndef EFC_DEFS_SVH
`define EFC_DEFS_SVH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define EFC_ADDR_W        14
`define EFC_IDX_W         12
`define EFC_DATA_W        32

// ****************************************************************
// Register indices
// ****************************************************************
`define EFC_IDX_A_TAP7    12'h425
`define EFC_IDX_A_TAP8    12'h427
`define EFC_IDX_A_TAP9    12'h429
`define EFC_IDX_B_TAP1    12'h448
`define EFC_IDX_B_TAP2    12'h44A
`define EFC_IDX_INFO      12'h4F0

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define EFC_REG_W         16
`define EFC_COEF_MSB      11
`define EFC_COEF_W        12
`define EFC_CENTER_W      18
`define EFC_NUM_TAPS      8'h09
`define EFC_NUM_REGS      5
`define EFC_REG_RST       16'h0000
`define EFC_COEF_RST      12'h000

`endif

// [efc_pkg.sv]
// Purpose: Types for the equaliser filter coefficient bank.
// Assumes: efc_defs.svh holds every width except those of slot and state.
// Notes:   Centre tap type is for the filter datapath outside.
`include "efc_defs.svh"

package efc_pkg;

   typedef logic signed [`EFC_COEF_W-1:0]   efc_coef_t;
   typedef logic signed [`EFC_CENTER_W-1:0] efc_center_t;
   typedef logic [`EFC_REG_W-1:0]           efc_word_t;
   typedef logic [2:0]                      efc_slot_t;

   typedef enum logic {
      EFC_ST_IDLE = 1'b0,
      EFC_ST_ANSW = 1'b1
   } efc_state_t;

endpackage

// [tb_efc_coef_regs.sv]
// Purpose: Self-checking bench for the equaliser filter coefficient bank.
// Assumes: APB answer after one wait state; taps lag registers one clock.
// Notes:   Inputs change by non-blocking assignment at the rising edge.
`timescale 1ns/10ps
`include "efc_defs.svh"

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t got %h want %h", $time, (g), (e)); end end

module tb_efc_coef_regs;
   import efc_pkg::*;
   logic        mclk = 1'b0, sys_rst = 1'b1, ce = 1'b1, single_chan_mode = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [13:0] paddr = 14'h0000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [3:0]  pstrb = 4'hF;
   logic        er;
   efc_coef_t   a_tap7_coef, a_tap8_coef, a_tap9_coef, b_tap1_coef, b_tap2_coef;
   int          bad_count = 0, comparisons = 0;
   logic [13:0] adr [5] = '{{`EFC_IDX_A_TAP7, 2'b00}, {`EFC_IDX_A_TAP8, 2'b00},
      {`EFC_IDX_A_TAP9, 2'b00}, {`EFC_IDX_B_TAP1, 2'b00},
      {`EFC_IDX_B_TAP2, 2'b00}};
   logic [15:0] val [5] = '{16'hF123, 16'hA7FE, 16'h5801, 16'hC456, 16'h3ABC};

   // ****************************************************************
   // Clock, design
   // ****************************************************************
   always #5 mclk = ~mclk;

   efc_coef_regs efc_coef_regs_inst (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
      .single_chan_mode(single_chan_mode), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .a_tap7_coef(a_tap7_coef), .a_tap8_coef(a_tap8_coef),
      .a_tap9_coef(a_tap9_coef), .b_tap1_coef(b_tap1_coef),
      .b_tap2_coef(b_tap2_coef));

   // ****************************************************************
   // Bus tasks
   // ****************************************************************
   task automatic apb(input logic w, input logic [13:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge mclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w;
      paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle();
      // Taps follow the stored word one clock after the answer edge
      repeat (2) @(posedge mclk);
   endtask

   task automatic do_reset();
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_zero();
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, adr[i], 32'h0, 4'hF);
         `CHK(rd, 32'h0000_0000)
      end
      `CHK({a_tap7_coef, a_tap8_coef, a_tap9_coef, b_tap1_coef, b_tap2_coef},
           60'h0)
   endtask

   task automatic t_map();
      for (int i = 0; i < 5; i++)
         apb(1'b1, adr[i], {16'hFFFF, val[i]}, 4'hF);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, adr[i], 32'h0, 4'hF);
         `CHK(rd, {16'h0000, val[i]})
      end
      settle();
      `CHK(a_tap7_coef, val[0][11:0])
      `CHK(a_tap8_coef, val[1][11:0])
      `CHK(a_tap9_coef, val[2][11:0])
      `CHK(b_tap1_coef, val[3][11:0])
      `CHK(b_tap2_coef, val[4][11:0])
      `CHK(a_tap8_coef < 0, 1'b0)
      `CHK(a_tap9_coef < 0, 1'b1)
   endtask

   task automatic t_mode();
      single_chan_mode <= 1'b1;
      settle();
      `CHK({b_tap1_coef, b_tap2_coef}, 24'h0)
      `CHK(a_tap7_coef, val[0][11:0])
      apb(1'b1, adr[4], 32'h0000_0777, 4'hF);
      settle();
      `CHK(b_tap2_coef, 12'h000)
      single_chan_mode <= 1'b0;
      settle();
      `CHK(b_tap2_coef, 12'h777)
      `CHK(b_tap1_coef, val[3][11:0])
      ce <= 1'b0;
      single_chan_mode <= 1'b1;
      settle();
      `CHK(b_tap2_coef, 12'h777)
      ce <= 1'b1;
      single_chan_mode <= 1'b0;
   endtask

   task automatic t_refuse();
      apb(1'b0, 14'h1098, 32'h0, 4'hF);
      `CHK({er, rd}, {1'b1, 32'h0})
      apb(1'b1, adr[1] | 14'h0001, 32'h0000_0111, 4'hF);
      `CHK(er, 1'b1)
      apb(1'b0, adr[1], 32'h0, 4'hF);
      `CHK({er, rd}, {1'b0, 16'h0000, val[1]})
      apb(1'b1, {`EFC_IDX_INFO, 2'b00}, 32'h0000_FFFF, 4'hF);
      apb(1'b0, {`EFC_IDX_INFO, 2'b00}, 32'h0, 4'hF);
      `CHK({er, rd}, {1'b0, 32'h0000_1209})
      apb(1'b1, adr[2], 32'h0000_ABCD, 4'h1);
      apb(1'b0, adr[2], 32'h0, 4'hF);
      `CHK(rd, {16'h0000, val[2][15:8], 8'hCD})
      apb(1'b1, adr[0], {20'h00000, val[0][11:0]}, 4'hF);
      settle();
      `CHK(a_tap7_coef, val[0][11:0])
   endtask

   task automatic t_rereset();
      do_reset();
      settle();
      `CHK(a_tap9_coef, 12'h000)
      t_zero();
   endtask

   task automatic test_done();
      if (bad_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      t_zero();
      t_map();
      t_mode();
      t_refuse();
      t_rereset();
      test_done();
   end

   // Whole run needs well under two hundred clocks; far beyond that is a hang
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      test_done();
   end
endmodule
